/* File: hw/sjtap_pkg.sv */
/*
 * constants, state codes and state records of the sram test access port.
 * assumes one link clock from the test controller and one system clock.
 */
// Notes on behaviour
// - tms and tdi float high; tck tied low keeps the port inert
// - inputs sampled on rising test clock, outputs driven from falling edge; here only tdo is, the pin-ring outputs follow the system clock
// - serial data enters the selected register msb and leaves its lsb
// - power-up reset idles tdo in high impedance, memory undisturbed
// - the instruction selects exactly one register between tdi and tdo
// - three-bit instruction, set to identify at power up and reset state
// - capture-ir loads 01 into the two low instruction shift bits
// - bypass is one bit, cleared at every capture-dr whatever the instruction
// - capture-dr loads the pin ring; shift-dr shifts it
// - the chain also holds cells for unused no-connect pins
// - identify instruction captures a fixed 32-bit identity word
// - instructions shift in shift-ir and take effect at update-ir
// - sample-z selects the boundary chain and floats the output bus
// - sample/preload capture snapshots all pin values
// - preload shifts in during capture shift-out, latched at update-dr
// - bypass routes tdi to tdo through the single bit
// - extest drives preloaded values out and selects the boundary chain
// - cell 108 latched at update-dr gates the output bus under extest
// - output-enable cell preset high at power up and in reset state
// - codes: 000 extest, 001 identify, 010 sample-z, 100 sample, 111 bypass
// - identity: revision 31:29, type 28:12, vendor 11:1, bit 0 one
package sjtap_pkg;
    localparam int BSR_W = 109;
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int OE_CELL = 108;
    localparam logic [IR_W-1:0] IR_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] IR_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] IR_SAMPLEZ = 3'h2;
    localparam logic [IR_W-1:0] IR_SAMPLE = 3'h4;
    localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
    // identity fields; values are arbitrary
    localparam logic [2:0] ID_REV = 3'h0;
    localparam logic [16:0] ID_PART = 17'h02468;
    localparam logic [10:0] ID_VENDOR = 11'h2A5;
    localparam logic [ID_W-1:0] ID_WORD = {ID_REV, ID_PART, ID_VENDOR, 1'h1};
    localparam logic [BSR_W-1:0] PRELOAD_RST = {1'h1, 108'h0};

    typedef enum logic [3:0] {
        ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SDR = 4'h3, ST_CDR = 4'h2,
        ST_SHDR = 4'h6, ST_E1DR = 4'h7, ST_PDR = 4'hF, ST_E2DR = 4'hE,
        ST_UDR = 4'h5, ST_SIR = 4'h4, ST_CIR = 4'hC, ST_SHIR = 4'hD,
        ST_E1IR = 4'h9, ST_PIR = 4'hB, ST_E2IR = 4'hA, ST_UIR = 4'h8
    } sjtap_state_t;

    typedef struct packed {
        logic ce_s1;
        logic ce_s2;
        logic [BSR_W-1:0] ring_s1;
        logic [BSR_W-1:0] ring_s2;
        sjtap_state_t st;
        logic [IR_W-1:0] ir;
        logic [IR_W-1:0] ir_sh;
        logic byp;
        logic [ID_W-1:0] id_sh;
        logic [BSR_W-1:0] bsr_sh;
        logic [BSR_W-1:0] preload;
        logic upd_tgl;
    } sjtap_tck_t;

    typedef struct packed {
        logic tdo;
        logic tdo_oe_n;
    } sjtap_neg_t;

    typedef struct packed {
        logic tg_s1;
        logic tg_s2;
        logic tg_d;
        logic [BSR_W-1:0] drive;
        logic extest;
        logic qoe;
    } sjtap_ref_t;
endpackage : sjtap_pkg

/* File: hw/sjtap_top.sv */
/*
 * test access port of the burst sram: tap controller, instruction,
 * bypass, identity and boundary registers on the test clock, and the
 * pin-ring control outputs on the system clock.
 * assumes pull-ups on tms and tdi are resolved outside, and that the
 * system clock is much faster than the test clock.
 */
`timescale 1ns/1ps
module sjtap_top (
    // system clock, reset, enable
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    // test port
    input wire logic I_TCK,
    input wire logic I_TMS,
    input wire logic I_TDI,
    output logic O_TDO,
    output logic O_TDO_OE_N,
    // pin ring
    input wire logic [sjtap_pkg::BSR_W-1:0] I_RING_IN,
    output logic [sjtap_pkg::BSR_W-1:0] O_RING_OUT,
    output logic O_RING_DRIVE,
    output logic O_QBUS_OE
);

    sjtap_pkg::sjtap_tck_t t_reg;
    sjtap_pkg::sjtap_tck_t t_next;
    sjtap_pkg::sjtap_neg_t n_reg;
    sjtap_pkg::sjtap_neg_t n_next;
    sjtap_pkg::sjtap_ref_t r_reg;
    sjtap_pkg::sjtap_ref_t r_next;
    sjtap_pkg::sjtap_state_t st_next;
    logic bsr_sel;
    logic id_sel;

    // one register between tdi and tdo; reserved codes fall to bypass
    always_comb begin
        bsr_sel = (t_reg.ir == sjtap_pkg::IR_EXTEST) ||
                  (t_reg.ir == sjtap_pkg::IR_SAMPLEZ) ||
                  (t_reg.ir == sjtap_pkg::IR_SAMPLE);
        id_sel = (t_reg.ir == sjtap_pkg::IR_IDCODE);
    end

    // controller walk; tms idling high stays in reset
    always_comb begin
        case (t_reg.st)
            sjtap_pkg::ST_TLR: begin
                st_next = I_TMS ? sjtap_pkg::ST_TLR : sjtap_pkg::ST_RTI;
            end
            sjtap_pkg::ST_RTI: begin
                st_next = I_TMS ? sjtap_pkg::ST_SDR : sjtap_pkg::ST_RTI;
            end
            sjtap_pkg::ST_SDR: begin
                st_next = I_TMS ? sjtap_pkg::ST_SIR : sjtap_pkg::ST_CDR;
            end
            sjtap_pkg::ST_CDR: begin
                st_next = I_TMS ? sjtap_pkg::ST_E1DR : sjtap_pkg::ST_SHDR;
            end
            sjtap_pkg::ST_SHDR: begin
                st_next = I_TMS ? sjtap_pkg::ST_E1DR : sjtap_pkg::ST_SHDR;
            end
            sjtap_pkg::ST_E1DR: begin
                st_next = I_TMS ? sjtap_pkg::ST_UDR : sjtap_pkg::ST_PDR;
            end
            sjtap_pkg::ST_PDR: begin
                st_next = I_TMS ? sjtap_pkg::ST_E2DR : sjtap_pkg::ST_PDR;
            end
            sjtap_pkg::ST_E2DR: begin
                st_next = I_TMS ? sjtap_pkg::ST_UDR : sjtap_pkg::ST_SHDR;
            end
            sjtap_pkg::ST_UDR: begin
                st_next = I_TMS ? sjtap_pkg::ST_SDR : sjtap_pkg::ST_RTI;
            end
            sjtap_pkg::ST_SIR: begin
                st_next = I_TMS ? sjtap_pkg::ST_TLR : sjtap_pkg::ST_CIR;
            end
            sjtap_pkg::ST_CIR: begin
                st_next = I_TMS ? sjtap_pkg::ST_E1IR : sjtap_pkg::ST_SHIR;
            end
            sjtap_pkg::ST_SHIR: begin
                st_next = I_TMS ? sjtap_pkg::ST_E1IR : sjtap_pkg::ST_SHIR;
            end
            sjtap_pkg::ST_E1IR: begin
                st_next = I_TMS ? sjtap_pkg::ST_UIR : sjtap_pkg::ST_PIR;
            end
            sjtap_pkg::ST_PIR: begin
                st_next = I_TMS ? sjtap_pkg::ST_E2IR : sjtap_pkg::ST_PIR;
            end
            sjtap_pkg::ST_E2IR: begin
                st_next = I_TMS ? sjtap_pkg::ST_UIR : sjtap_pkg::ST_SHIR;
            end
            sjtap_pkg::ST_UIR: begin
                st_next = I_TMS ? sjtap_pkg::ST_SDR : sjtap_pkg::ST_RTI;
            end
            default: begin
                st_next = sjtap_pkg::ST_TLR;
            end
        endcase
    end

    // rising test clock: all port inputs sampled here
    always_comb begin
        t_next = t_reg;
        t_next.ce_s1 = I_CE;
        t_next.ce_s2 = t_reg.ce_s1;
        t_next.ring_s1 = I_RING_IN;
        t_next.ring_s2 = t_reg.ring_s1;
        if (t_reg.ce_s2) begin
            t_next.st = st_next;
            case (t_reg.st)
                sjtap_pkg::ST_CIR: begin
                    t_next.ir_sh = sjtap_pkg::IR_CAPTURE;
                end
                sjtap_pkg::ST_SHIR: begin
                    t_next.ir_sh = {I_TDI, t_reg.ir_sh[2:1]};
                end
                sjtap_pkg::ST_UIR: begin
                    t_next.ir = t_reg.ir_sh;
                    t_next.upd_tgl = ~t_reg.upd_tgl;
                end
                sjtap_pkg::ST_CDR: begin
                    t_next.byp = 1'h0;
                    if (id_sel) begin
                        t_next.id_sh = sjtap_pkg::ID_WORD;
                    end
                    if (bsr_sel) begin
                        // whole ring incl. no-connect cells
                        t_next.bsr_sh = t_reg.ring_s2;
                    end
                end
                sjtap_pkg::ST_SHDR: begin
                    if (bsr_sel) begin
                        t_next.bsr_sh = {I_TDI, t_reg.bsr_sh[108:1]};
                    end else if (id_sel) begin
                        t_next.id_sh = {I_TDI, t_reg.id_sh[31:1]};
                    end else begin
                        t_next.byp = I_TDI;
                    end
                end
                sjtap_pkg::ST_UDR: begin
                    if (bsr_sel) begin
                        t_next.preload = t_reg.bsr_sh;
                        t_next.upd_tgl = ~t_reg.upd_tgl;
                    end
                end
                default: begin
                    t_next.upd_tgl = t_reg.upd_tgl;
                end
            endcase
            if (st_next == sjtap_pkg::ST_TLR) begin
                t_next.ir = sjtap_pkg::IR_IDCODE;
                t_next.preload = sjtap_pkg::PRELOAD_RST;
                if (t_reg.st != sjtap_pkg::ST_TLR) begin
                    t_next.upd_tgl = ~t_reg.upd_tgl;
                end
            end
        end
    end

    // power-up reset touches only test logic
    always_ff @(posedge I_TCK or posedge I_RST) begin
        if (I_RST) begin
            t_reg <= '{
                ce_s1: 1'h0,
                ce_s2: 1'h0,
                ring_s1: '0,
                ring_s2: '0,
                st: sjtap_pkg::ST_TLR,
                ir: sjtap_pkg::IR_IDCODE,
                ir_sh: '0,
                byp: 1'h0,
                id_sh: '0,
                bsr_sh: '0,
                preload: sjtap_pkg::PRELOAD_RST,
                upd_tgl: 1'h0
            };
        end else begin
            t_reg <= t_next;
        end
    end

    // falling test clock: tdo from the lsb of the selected register
    always_comb begin
        n_next = n_reg;
        if (t_reg.ce_s2) begin
            n_next.tdo_oe_n = 1'h1;
            n_next.tdo = 1'h0;
            if (t_reg.st == sjtap_pkg::ST_SHIR) begin
                n_next.tdo_oe_n = 1'h0;
                n_next.tdo = t_reg.ir_sh[0];
            end else if (t_reg.st == sjtap_pkg::ST_SHDR) begin
                n_next.tdo_oe_n = 1'h0;
                if (bsr_sel) begin
                    n_next.tdo = t_reg.bsr_sh[0];
                end else if (id_sel) begin
                    n_next.tdo = t_reg.id_sh[0];
                end else begin
                    n_next.tdo = t_reg.byp;
                end
            end
        end
    end

    always_ff @(negedge I_TCK or posedge I_RST) begin
        if (I_RST) begin
            n_reg <= '{tdo: 1'h0, tdo_oe_n: 1'h1};
        end else begin
            n_reg <= n_next;
        end
    end

    // system side: toggle marks stable preload and instruction
    always_comb begin
        r_next = r_reg;
        if (I_CE) begin
            r_next.tg_s1 = t_reg.upd_tgl;
            r_next.tg_s2 = r_reg.tg_s1;
            r_next.tg_d = r_reg.tg_s2;
            if (r_reg.tg_s2 != r_reg.tg_d) begin
                r_next.drive = t_reg.preload;
                r_next.extest = (t_reg.ir == sjtap_pkg::IR_EXTEST);
                if (t_reg.ir == sjtap_pkg::IR_EXTEST) begin
                    r_next.qoe = t_reg.preload[sjtap_pkg::OE_CELL];
                end else begin
                    r_next.qoe = (t_reg.ir != sjtap_pkg::IR_SAMPLEZ);
                end
            end
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            r_reg <= '{
                tg_s1: 1'h0,
                tg_s2: 1'h0,
                tg_d: 1'h0,
                drive: '0,
                extest: 1'h0,
                qoe: 1'h1
            };
        end else begin
            r_reg <= r_next;
        end
    end

    assign O_TDO = n_reg.tdo;
    assign O_TDO_OE_N = n_reg.tdo_oe_n;
    assign O_RING_OUT = r_reg.drive;
    assign O_RING_DRIVE = r_reg.extest;
    assign O_QBUS_OE = r_reg.qoe;

    a_tms_reset: assert property (
        @(posedge I_TCK) disable iff (I_RST)
        (t_reg.ce_s2 && I_TMS) [*5] |=> t_reg.st == sjtap_pkg::ST_TLR)
        else $error("five tms-high clocks did not reach reset state");

    a_reset_idcode: assert property (
        @(posedge I_TCK) disable iff (I_RST)
        t_reg.st == sjtap_pkg::ST_TLR |-> t_reg.ir == sjtap_pkg::IR_IDCODE)
        else $error("instruction not identify in reset state");

    a_ir_capture: assert property (
        @(posedge I_TCK) disable iff (I_RST)
        (t_reg.st == sjtap_pkg::ST_CIR && t_reg.ce_s2) |=> t_reg.ir_sh[1:0] == 2'h1)
        else $error("capture-ir pattern wrong");

    a_ir_hold: assert property (
        @(posedge I_TCK) disable iff (I_RST)
        (t_reg.st != sjtap_pkg::ST_UIR && st_next != sjtap_pkg::ST_TLR)
        |=> $stable(t_reg.ir))
        else $error("instruction changed outside update-ir");

    a_id_capture: assert property (
        @(posedge I_TCK) disable iff (I_RST)
        (t_reg.st == sjtap_pkg::ST_CDR && id_sel && t_reg.ce_s2)
        |=> t_reg.id_sh == sjtap_pkg::ID_WORD)
        else $error("identity word not captured");

    a_bypass_clear: assert property (
        @(posedge I_TCK) disable iff (I_RST)
        (t_reg.st == sjtap_pkg::ST_CDR && t_reg.ce_s2) |=> !t_reg.byp)
        else $error("bypass bit not cleared at capture");

    a_tdo_enable: assert property (
        @(posedge I_TCK) disable iff (I_RST)
        t_reg.ce_s2 |-> O_TDO_OE_N == !((t_reg.st == sjtap_pkg::ST_SHIR) ||
                                        (t_reg.st == sjtap_pkg::ST_SHDR)))
        else $error("tdo enable out of shift states");

    a_oe_preset: assert property (
        @(posedge I_TCK) disable iff (I_RST)
        t_reg.st == sjtap_pkg::ST_TLR |-> t_reg.preload[sjtap_pkg::OE_CELL])
        else $error("output-enable cell not preset");

    a_msb_entry: assert property (
        @(posedge I_TCK) disable iff (I_RST)
        (t_reg.st == sjtap_pkg::ST_SHDR && bsr_sel && t_reg.ce_s2)
        |=> t_reg.bsr_sh[108] == $past(I_TDI))
        else $error("tdi did not enter the msb");

    a_bypass_path: assert property (
        @(posedge I_TCK) disable iff (I_RST)
        (t_reg.st == sjtap_pkg::ST_SHDR && !bsr_sel && !id_sel && t_reg.ce_s2)
        |=> t_reg.byp == $past(I_TDI))
        else $error("bypass bit did not take tdi");

    a_id_shift: assert property (
        @(posedge I_TCK) disable iff (I_RST)
        (t_reg.st == sjtap_pkg::ST_SHDR && id_sel && t_reg.ce_s2)
        |=> t_reg.id_sh[31] == $past(I_TDI))
        else $error("tdi did not enter the identity msb");

    a_ir_update: assert property (
        @(posedge I_TCK) disable iff (I_RST)
        (t_reg.st == sjtap_pkg::ST_UIR && t_reg.ce_s2) |=> t_reg.ir == $past(t_reg.ir_sh))
        else $error("instruction not taken at update-ir");

    a_preload_update: assert property (
        @(posedge I_TCK) disable iff (I_RST)
        (t_reg.st == sjtap_pkg::ST_UDR && bsr_sel && t_reg.ce_s2)
        |=> t_reg.preload == $past(t_reg.bsr_sh))
        else $error("preload not latched at update-dr");

    a_tdo_lsb: assert property (
        @(posedge I_TCK) disable iff (I_RST)
        (t_reg.st == sjtap_pkg::ST_SHDR && bsr_sel && t_reg.ce_s2)
        |-> O_TDO == t_reg.bsr_sh[0])
        else $error("tdo not the boundary lsb");

    a_samplez_float: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        (I_CE && r_reg.tg_s2 != r_reg.tg_d && t_reg.ir == sjtap_pkg::IR_SAMPLEZ)
        |=> !O_QBUS_OE)
        else $error("output bus not floated under sample-z");

    a_extest_gate: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        (I_CE && r_reg.tg_s2 != r_reg.tg_d && t_reg.ir == sjtap_pkg::IR_EXTEST)
        |=> O_QBUS_OE == $past(t_reg.preload[sjtap_pkg::OE_CELL]))
        else $error("bus enable not from the gate cell");

    a_extest_drive: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        (I_CE && r_reg.tg_s2 != r_reg.tg_d)
        |=> O_RING_DRIVE == ($past(t_reg.ir) == sjtap_pkg::IR_EXTEST) &&
            O_RING_OUT == $past(t_reg.preload))
        else $error("ring drive does not follow the instruction");

endmodule : sjtap_top

/* File: verif/sjtap_ctrl_model.sv */
/*
 * board-level test controller model for the test access port.
 * assumes it is the only driver of tck, tms and tdi; tck runs only in frames.
 */
`timescale 1ns/1ps
module sjtap_ctrl_model (
    // test port toward the device
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    input wire logic i_tdo
);
    // tck rests low between frames, tms and tdi at pull-up level
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
    end

    // one tck cycle: change while low, take tdo just before the rise
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #62.5;
        tdo = i_tdo;
        o_tck = 1'b1;
        #62.5;
        o_tck = 1'b0;
    endtask : tick

    // n rises with tms high, then one to run-test/idle
    task automatic tms_reset(input int n);
        logic d;
        for (int i = 0; i < n; i++) begin
            tick(1'b1, 1'b1, d);
        end
        tick(1'b0, 1'b1, d);
        o_tms = 1'b1;
    endtask : tms_reset

    // full ir or dr frame from run-test/idle back to it, lsb first
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic d;
        dout = '0;
        tick(1'b1, 1'b1, d);
        if (ir) begin
            tick(1'b1, 1'b1, d);
        end
        tick(1'b0, 1'b1, d);
        tick(1'b0, 1'b1, d);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], d);
            dout[i] = d;
        end
        // update then idle; callers pass only implemented codes
        tick(1'b1, 1'b1, d);
        tick(1'b0, 1'b1, d);
        o_tms = 1'b1;
        o_tdi = 1'b1;
    endtask : scan
endmodule : sjtap_ctrl_model

/* File: verif/sjtap_top_tb_top.sv */
/*
 * self-checking bench of the test access port.
 * assumes the controller model drives the test port; pin ring held stable.
 */
`timescale 1ns/1ps
module sjtap_top_tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b0;
    logic ce;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe_n;
    logic [sjtap_pkg::BSR_W-1:0] ring_in;
    logic [sjtap_pkg::BSR_W-1:0] ring_out;
    logic ring_drive;
    logic qbus_oe;
    logic [127:0] dout;
    int mismatches = 0;
    int total_checks = 0;
    // captured ring and preload patterns
    localparam logic [108:0] RING = {1'h1, {27{4'h5}}};
    localparam logic [108:0] PRE = {1'h0, {27{4'h3}}};

    always #2.5 ref_clk = ~ref_clk;

    sjtap_top sjtap_top_i (
        .I_REF_CLK(ref_clk), .I_RST(rst), .I_CE(ce), .I_TCK(tck), .I_TMS(tms),
        .I_TDI(tdi), .O_TDO(tdo), .O_TDO_OE_N(tdo_oe_n), .I_RING_IN(ring_in),
        .O_RING_OUT(ring_out), .O_RING_DRIVE(ring_drive), .O_QBUS_OE(qbus_oe)
    );
    // a released tdo line reads high at the controller
    sjtap_ctrl_model sjtap_ctrl_model_i (
        .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo_oe_n ? 1'b1 : tdo)
    );

    task automatic check(input string what, input logic [127:0] exp,
                         input logic [127:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic sys_wait();
        repeat (10) @(posedge ref_clk);
    endtask : sys_wait

    task automatic t_power_up();
        check("tdo enable", 128'(1'b1), 128'(tdo_oe_n));
        check("bus enable", 128'(1'b1), 128'(qbus_oe));
        check("ring drive", 128'(1'b0), 128'(ring_drive));
        sjtap_ctrl_model_i.tms_reset(8);
        sjtap_ctrl_model_i.scan(1'b0, 32, '0, dout);
        check("identity", 128'(sjtap_pkg::ID_WORD), 128'(dout[31:0]));
        check("identity bit0", 128'(1'b1), 128'(dout[0]));
        $display("test power_up done");
    endtask : t_power_up

    task automatic t_ir_and_bypass();
        sjtap_ctrl_model_i.scan(1'b1, 3, 128'(sjtap_pkg::IR_BYPASS), dout);
        check("ir capture", 128'(2'h1), 128'(dout[1:0]));
        check("tdo idle", 128'(1'b1), 128'(tdo_oe_n));
        sjtap_ctrl_model_i.scan(1'b0, 8, 128'(8'hA5), dout);
        check("bypass", 128'(8'h4A), 128'(dout[7:0]));
        $display("test ir_and_bypass done");
    endtask : t_ir_and_bypass

    task automatic t_sample_extest();
        sjtap_ctrl_model_i.scan(1'b1, 3, 128'(sjtap_pkg::IR_SAMPLE), dout);
        sjtap_ctrl_model_i.scan(1'b0, 109, 128'(PRE), dout);
        check("sample capture", 128'(RING), 128'(dout[108:0]));
        sys_wait();
        check("sample drive", 128'(1'b0), 128'(ring_drive));
        check("sample bus", 128'(1'b1), 128'(qbus_oe));
        sjtap_ctrl_model_i.scan(1'b1, 3, 128'(sjtap_pkg::IR_EXTEST), dout);
        sys_wait();
        check("extest drive", 128'(1'b1), 128'(ring_drive));
        check("extest out", 128'(PRE), 128'(ring_out));
        check("extest bus off", 128'(1'b0), 128'(qbus_oe));
        sjtap_ctrl_model_i.scan(1'b0, 109, 128'({1'h1, 108'h0}), dout);
        check("extest capture", 128'(RING), 128'(dout[108:0]));
        sys_wait();
        check("extest bus on", 128'(1'b1), 128'(qbus_oe));
        $display("test sample_extest done");
    endtask : t_sample_extest

    task automatic t_samplez_reset();
        sjtap_ctrl_model_i.scan(1'b1, 3, 128'(sjtap_pkg::IR_SAMPLEZ), dout);
        sys_wait();
        check("samplez bus", 128'(1'b0), 128'(qbus_oe));
        sjtap_ctrl_model_i.scan(1'b0, 109, 128'(PRE), dout);
        check("samplez capture", 128'(RING), 128'(dout[108:0]));
        sys_wait();
        check("samplez bus held", 128'(1'b0), 128'(qbus_oe));
        sjtap_ctrl_model_i.tms_reset(5);
        sys_wait();
        check("reset bus", 128'(1'b1), 128'(qbus_oe));
        check("reset drive", 128'(1'b0), 128'(ring_drive));
        sjtap_ctrl_model_i.scan(1'b0, 32, '0, dout);
        check("reset identity", 128'(sjtap_pkg::ID_WORD), 128'(dout[31:0]));
        sjtap_ctrl_model_i.scan(1'b1, 3, 128'(sjtap_pkg::IR_EXTEST), dout);
        sys_wait();
        check("preset cell", 128'(1'b1), 128'(qbus_oe));
        check("preset out", 128'(sjtap_pkg::PRELOAD_RST), 128'(ring_out));
        $display("test samplez_reset done");
    endtask : t_samplez_reset

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        rst <= 1'b1;
        ce = 1'b1;
        ring_in = '0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        ring_in <= RING;
        sys_wait();
        t_power_up();
        t_ir_and_bypass();
        t_sample_extest();
        t_samplez_reset();
        report_and_stop();
    end

    // watchdog well beyond the roughly 62 us of scan traffic
    initial begin
        #200_000;
        mismatches++;
        report_and_stop();
    end
endmodule : sjtap_top_tb_top
